// file: core/event_router_pkg.sv
// Constants and carrier types for the event output router.
// Assumes a single 100 MHz core clock and a plain register port.
package event_router_pkg;

  localparam int unsigned NUM_EVENTS = 20;
  localparam int unsigned NUM_LINES  = 12;
  localparam int unsigned NUM_FLAGS  = 11;

  localparam logic [6:0] MODE_IDX_MIN  = 7'h15;
  localparam logic [6:0] MODE_IDX_MAX  = 7'h28;
  localparam logic [6:0] ALARM_IDX_MIN = 7'h3d;
  localparam logic [6:0] ALARM_IDX_MAX = 7'h50;

  localparam logic [3:0] SLOT_NONE = 4'h0;
  localparam logic [3:0] SLOT_MAX  = 4'hc;
  localparam logic [3:0] SLOT_PWM1 = 4'h1;
  localparam logic [3:0] SLOT_PWM2 = 4'h2;

  localparam logic [6:0] DELAY_MAX = 7'h63;

  // Clock rate and timing.
  localparam longint unsigned CLK_HZ        = 100000000;
  localparam longint unsigned SECOND_S      = 1;
  localparam longint unsigned SECOND_CYCLES = SECOND_S * CLK_HZ;
  localparam longint unsigned SCAN_MS       = 1;
  localparam longint unsigned SCAN_CYCLES   = SCAN_MS * CLK_HZ / 1000;

  // Register addresses.
  localparam logic [3:0] ADDR_MODE_SEL   = 4'h0;
  localparam logic [3:0] ADDR_ALARM_SEL  = 4'h1;
  localparam logic [3:0] ADDR_STEP       = 4'h2;
  localparam logic [3:0] ADDR_MODE_CFG   = 4'h3;
  localparam logic [3:0] ADDR_ALARM_CFG  = 4'h4;
  localparam logic [3:0] ADDR_ALARM_INNR = 4'h5;
  localparam logic [3:0] ADDR_PWM_USE    = 4'h6;
  localparam logic [3:0] ADDR_LINE_STAT  = 4'h7;

  // Step register bits.
  localparam int unsigned STEP_MODE_UP   = 0;
  localparam int unsigned STEP_MODE_DOWN = 1;
  localparam int unsigned STEP_ALM_UP    = 2;
  localparam int unsigned STEP_ALM_DOWN  = 3;

  // Field positions in write data.
  localparam int unsigned F_FLAG_LO  = 0;
  localparam int unsigned F_SRC_LO   = 4;
  localparam int unsigned F_COND     = 6;
  localparam int unsigned F_SLOT_LO  = 8;
  localparam int unsigned F_ATYPE_LO = 0;
  localparam int unsigned F_ACTION   = 2;
  localparam int unsigned F_ALOOP    = 3;
  localparam int unsigned F_TNUM_LO  = 0;
  localparam int unsigned F_DELAY_LO = 8;

  typedef enum logic [3:0] {
    FLAG_STOP  = 4'h0,
    FLAG_RUN   = 4'h1,
    FLAG_READY = 4'h2,
    FLAG_END   = 4'h3,
    FLAG_TROUBLE_STATE  = 4'h4,
    FLAG_HOLD  = 4'h5,
    FLAG_WAIT  = 4'h6,
    FLAG_TUNE  = 4'h7,
    FLAG_FIX   = 4'h8,
    FLAG_DOWN  = 4'h9,
    FLAG_UP    = 4'ha
  } flag_sel_type;

  typedef enum logic [1:0] {
    SRC_LOOP_ONE = 2'h0,
    SRC_LOOP_TWO = 2'h1,
    SRC_BOTH     = 2'h2
  } src_type;

  typedef enum logic [1:0] {
    ALM_INNER = 2'h0,
    ALM_BREAK = 2'h1,
    ALM_FAIL  = 2'h2
  } alarm_kind_type;

  typedef struct packed {
    logic quit;
    logic ready;
    logic end_st;
    logic brk;
    logic trouble_state;
    logic running;
    logic hold;
    logic tune;
    logic wait_st;
    logic fix_mode;
    logic target_down;
    logic target_up;
    logic sensor_burnout;
  } loop_state_type;

  typedef struct packed {
    logic sram_err;
    logic flash_err;
    logic prog_err;
    logic power_restart;
    logic tune_fail;
  } fault_type;

  typedef struct packed {
    logic [3:0] flag;
    logic [1:0] src;
    logic       cond_and;
    logic [3:0] slot;
  } mode_cfg_type;

  typedef struct packed {
    logic [1:0] kind;
    logic       action_all;
    logic       loop_two;
    logic [3:0] slot;
    logic [7:0] type_num;
    logic [6:0] delay_s;
  } alarm_cfg_type;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_type;

endpackage

// file: core/event_output_router.sv
// Event output router: maps loop mode flags and alarm conditions onto
// twelve discrete output lines, configured over a plain register port.
// Assumes synchronous inputs, a 100 MHz clock and an outside threshold
// comparator that reports one hit per alarm index.
`timescale 1ns/1ps
`default_nettype none

module event_output_router #(
  parameter longint unsigned SCAN_PERIOD   = event_router_pkg::SCAN_CYCLES,
  parameter longint unsigned SECOND_PERIOD = event_router_pkg::SECOND_CYCLES
) (
  input  wire logic                                I_MCLK,
  input  wire logic                                I_RSTN,
  input  wire event_router_pkg::reg_req_type       I_REQ,
  output logic [15:0]                              O_RDATA,
  input  wire event_router_pkg::loop_state_type    I_LOOP_ONE,
  input  wire event_router_pkg::loop_state_type    I_LOOP_TWO,
  input  wire event_router_pkg::fault_type         I_FAULT,
  input  wire logic [19:0]                         I_THRESH_HIT,
  output logic [11:0]                              O_LINES,
  output logic [1:0]                               O_DRIVE_ZERO,
  output logic [159:0]                             O_INNER_TYPE
);

  typedef struct packed {
    event_router_pkg::mode_cfg_type [19:0]  mode_cfg;
    event_router_pkg::alarm_cfg_type [19:0] alarm_cfg;
    logic [6:0]                             mode_sel;
    logic [6:0]                             alarm_sel;
    logic [1:0]                             pwm_use;
    logic [15:0]                            rdata;
    logic [11:0]                            lines;
    logic [1:0]                             drive_zero;
    logic [31:0]                            scan_cnt;
    logic [31:0]                            sec_cnt;
    logic [19:0][6:0]                       dly_cnt;
    logic [19:0]                            inner_state;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  logic [event_router_pkg::NUM_FLAGS-1:0] flags_one;
  logic [event_router_pkg::NUM_FLAGS-1:0] flags_two;
  logic [19:0]                            mode_on;
  logic [19:0]                            alarm_raw;
  logic [19:0]                            alarm_on;
  logic [19:0]                            alarm_break_on;
  logic                                   fail_any;
  logic                                   scan_tick;
  logic                                   sec_tick;

  function automatic logic [10:0] make_flags(input event_router_pkg::loop_state_type s);
    logic        run;
    logic [10:0] f;
    run = s.running | s.hold | s.tune | s.wait_st;
    f   = '0;
    f[event_router_pkg::FLAG_STOP]  = s.quit | s.ready | s.end_st | s.brk
                                      | s.trouble_state;
    f[event_router_pkg::FLAG_RUN]   = run;
    f[event_router_pkg::FLAG_READY] = s.ready;
    f[event_router_pkg::FLAG_END]   = s.end_st;
    f[event_router_pkg::FLAG_TROUBLE_STATE]  = s.trouble_state;
    f[event_router_pkg::FLAG_HOLD]  = s.hold;
    f[event_router_pkg::FLAG_WAIT]  = s.wait_st;
    f[event_router_pkg::FLAG_TUNE]  = s.tune;
    f[event_router_pkg::FLAG_FIX]   = s.fix_mode;
    f[event_router_pkg::FLAG_DOWN]  = run & s.target_down;
    f[event_router_pkg::FLAG_UP]    = run & s.target_up;
    return f;
  endfunction

  assign flags_one = make_flags(I_LOOP_ONE);
  assign flags_two = make_flags(I_LOOP_TWO);

  assign fail_any = I_FAULT.sram_err | I_FAULT.flash_err | I_FAULT.prog_err
                    | I_FAULT.power_restart | I_FAULT.tune_fail;

  assign scan_tick = (state_r.scan_cnt == 32'(SCAN_PERIOD - 1));
  assign sec_tick  = (state_r.sec_cnt == 32'(SECOND_PERIOD - 1));

  // Per-entry evaluation of mode events and alarm conditions.
  genvar g;
  generate
    for (g = 0; g < 20; g = g + 1) begin : g_entry
      event_router_pkg::mode_cfg_type  mc;
      event_router_pkg::alarm_cfg_type ac;
      logic                            f1;
      logic                            f2;
      logic                            run_ok;
      logic                            burnout;

      assign mc      = state_r.mode_cfg[g];
      assign ac      = state_r.alarm_cfg[g];
      assign f1      = (mc.flag < 4'(event_router_pkg::NUM_FLAGS)) ? flags_one[mc.flag] : 1'b0;
      assign f2      = (mc.flag < 4'(event_router_pkg::NUM_FLAGS)) ? flags_two[mc.flag] : 1'b0;
      assign run_ok  = ac.loop_two ? flags_two[event_router_pkg::FLAG_RUN]
                                   : flags_one[event_router_pkg::FLAG_RUN];
      assign burnout = ac.loop_two ? I_LOOP_TWO.sensor_burnout : I_LOOP_ONE.sensor_burnout;

      always_comb begin
        unique case (mc.src)
          event_router_pkg::SRC_LOOP_ONE: mode_on[g] = f1;
          event_router_pkg::SRC_LOOP_TWO: mode_on[g] = f2;
          event_router_pkg::SRC_BOTH:     mode_on[g] = mc.cond_and ? (f1 & f2)
                                                                   : (f1 | f2);
          default:                        mode_on[g] = 1'b0;
        endcase
      end

      always_comb begin
        unique case (ac.kind)
          event_router_pkg::ALM_INNER: alarm_raw[g] = I_THRESH_HIT[g];
          event_router_pkg::ALM_BREAK: alarm_raw[g] = burnout;
          event_router_pkg::ALM_FAIL:  alarm_raw[g] = fail_any;
          default:                     alarm_raw[g] = 1'b0;
        endcase
      end

      // Inner alarms act on the delayed state, the others at once.
      assign alarm_on[g] = ((ac.kind == event_router_pkg::ALM_INNER) ? state_r.inner_state[g]
                                                                     : alarm_raw[g])
                           & (ac.action_all | run_ok);
      assign alarm_break_on[g] = (ac.kind == event_router_pkg::ALM_BREAK) & alarm_on[g];
      assign O_INNER_TYPE[g*8 +: 8] = ac.type_num;
    end
  endgenerate

  always_comb begin
    logic [4:0]  mi;
    logic [4:0]  ai;
    logic [3:0]  wslot;
    logic        slot_ok;
    logic [11:0] line_nxt;
    logic [1:0]  zero_nxt;
    event_router_pkg::mode_cfg_type  mw;
    event_router_pkg::alarm_cfg_type aw;

    state_nxt = state_r;
    mi        = 5'(state_r.mode_sel - event_router_pkg::MODE_IDX_MIN);
    ai        = 5'(state_r.alarm_sel - event_router_pkg::ALARM_IDX_MIN);
    wslot     = I_REQ.wdata[event_router_pkg::F_SLOT_LO +: 4];
    slot_ok   = (wslot <= event_router_pkg::SLOT_MAX)
                && !(wslot == event_router_pkg::SLOT_PWM1 && state_r.pwm_use[0])
                && !(wslot == event_router_pkg::SLOT_PWM2 && state_r.pwm_use[1]);
    mw        = state_r.mode_cfg[mi];
    aw        = state_r.alarm_cfg[ai];
    line_nxt  = '0;
    zero_nxt  = '0;

    // Timebase dividers.
    state_nxt.scan_cnt = scan_tick ? '0 : state_r.scan_cnt + 32'h1;
    state_nxt.sec_cnt  = sec_tick ? '0 : state_r.sec_cnt + 32'h1;

    // Register writes.
    if (I_REQ.wr) begin
      unique case (I_REQ.addr)
        event_router_pkg::ADDR_MODE_SEL: begin
          if (I_REQ.wdata[6:0] >= event_router_pkg::MODE_IDX_MIN
              && I_REQ.wdata[6:0] <= event_router_pkg::MODE_IDX_MAX) begin
            state_nxt.mode_sel = I_REQ.wdata[6:0];
          end
        end
        event_router_pkg::ADDR_ALARM_SEL: begin
          if (I_REQ.wdata[6:0] >= event_router_pkg::ALARM_IDX_MIN
              && I_REQ.wdata[6:0] <= event_router_pkg::ALARM_IDX_MAX) begin
            state_nxt.alarm_sel = I_REQ.wdata[6:0];
          end
        end
        event_router_pkg::ADDR_STEP: begin
          if (I_REQ.wdata[event_router_pkg::STEP_MODE_UP]
              && state_r.mode_sel < event_router_pkg::MODE_IDX_MAX) begin
            state_nxt.mode_sel = state_r.mode_sel + 7'h1;
          end else if (I_REQ.wdata[event_router_pkg::STEP_MODE_DOWN]
                       && state_r.mode_sel > event_router_pkg::MODE_IDX_MIN) begin
            state_nxt.mode_sel = state_r.mode_sel - 7'h1;
          end
          if (I_REQ.wdata[event_router_pkg::STEP_ALM_UP]
              && state_r.alarm_sel < event_router_pkg::ALARM_IDX_MAX) begin
            state_nxt.alarm_sel = state_r.alarm_sel + 7'h1;
          end else if (I_REQ.wdata[event_router_pkg::STEP_ALM_DOWN]
                       && state_r.alarm_sel > event_router_pkg::ALARM_IDX_MIN) begin
            state_nxt.alarm_sel = state_r.alarm_sel - 7'h1;
          end
        end
        event_router_pkg::ADDR_MODE_CFG: begin
          mw.flag     = I_REQ.wdata[event_router_pkg::F_FLAG_LO +: 4];
          mw.src      = I_REQ.wdata[event_router_pkg::F_SRC_LO +: 2];
          mw.cond_and = I_REQ.wdata[event_router_pkg::F_COND];
          if (slot_ok) begin
            mw.slot = wslot;
          end
          state_nxt.mode_cfg[mi] = mw;
        end
        event_router_pkg::ADDR_ALARM_CFG: begin
          aw.kind       = I_REQ.wdata[event_router_pkg::F_ATYPE_LO +: 2];
          aw.action_all = I_REQ.wdata[event_router_pkg::F_ACTION];
          aw.loop_two   = I_REQ.wdata[event_router_pkg::F_ALOOP];
          if (slot_ok) begin
            aw.slot = wslot;
          end
          state_nxt.alarm_cfg[ai] = aw;
        end
        event_router_pkg::ADDR_ALARM_INNR: begin
          aw.type_num = I_REQ.wdata[event_router_pkg::F_TNUM_LO +: 8];
          aw.delay_s  = I_REQ.wdata[event_router_pkg::F_DELAY_LO +: 7];
          if (aw.delay_s > event_router_pkg::DELAY_MAX) begin
            aw.delay_s = event_router_pkg::DELAY_MAX;
          end
          state_nxt.alarm_cfg[ai] = aw;
        end
        event_router_pkg::ADDR_PWM_USE: begin
          state_nxt.pwm_use = I_REQ.wdata[1:0];
        end
        default: begin
        end
      endcase
    end

    // Register reads answer in the following cycle.
    state_nxt.rdata = '0;
    if (I_REQ.rd) begin
      unique case (I_REQ.addr)
        event_router_pkg::ADDR_MODE_SEL:   state_nxt.rdata = {9'h0, state_r.mode_sel};
        event_router_pkg::ADDR_ALARM_SEL:  state_nxt.rdata = {9'h0, state_r.alarm_sel};
        event_router_pkg::ADDR_MODE_CFG:   state_nxt.rdata = {4'h0, state_r.mode_cfg[mi].slot,
                                                              1'b0, state_r.mode_cfg[mi].cond_and,
                                                              state_r.mode_cfg[mi].src,
                                                              state_r.mode_cfg[mi].flag};
        event_router_pkg::ADDR_ALARM_CFG:  state_nxt.rdata = {4'h0, state_r.alarm_cfg[ai].slot,
                                                              4'h0, state_r.alarm_cfg[ai].loop_two,
                                                              state_r.alarm_cfg[ai].action_all,
                                                              state_r.alarm_cfg[ai].kind};
        event_router_pkg::ADDR_ALARM_INNR: state_nxt.rdata = {1'b0, state_r.alarm_cfg[ai].delay_s,
                                                              state_r.alarm_cfg[ai].type_num};
        event_router_pkg::ADDR_PWM_USE:    state_nxt.rdata = {14'h0, state_r.pwm_use};
        event_router_pkg::ADDR_LINE_STAT:  state_nxt.rdata = {2'h0, state_r.drive_zero,
                                                              state_r.lines};
        default:                           state_nxt.rdata = '0;
      endcase
    end

    // Inner alarm delay: a changed comparison must persist for the set seconds.
    for (int i = 0; i < 20; i++) begin
      if (alarm_raw[i] == state_r.inner_state[i]) begin
        state_nxt.dly_cnt[i] = '0;
      end else if (state_r.dly_cnt[i] >= state_r.alarm_cfg[i].delay_s) begin
        state_nxt.inner_state[i] = alarm_raw[i];
        state_nxt.dly_cnt[i]     = '0;
      end else if (sec_tick) begin
        state_nxt.dly_cnt[i] = state_r.dly_cnt[i] + 7'h1;
      end
    end

    // Line map: slot k drives line k-1 of O_LINES; slot zero drives nothing.
    for (int i = 0; i < 20; i++) begin
      for (int k = 0; k < 12; k++) begin
        if (state_r.mode_cfg[i].slot == 4'(k + 1) && mode_on[i]) begin
          line_nxt[k] = 1'b1;
        end
        if (state_r.alarm_cfg[i].slot == 4'(k + 1) && alarm_on[i]) begin
          line_nxt[k] = 1'b1;
        end
      end
      if (alarm_break_on[i]) begin
        zero_nxt[state_r.alarm_cfg[i].loop_two] = 1'b1;
      end
    end
    line_nxt[0] = line_nxt[0] & ~state_r.pwm_use[0];
    line_nxt[1] = line_nxt[1] & ~state_r.pwm_use[1];

    if (scan_tick) begin
      state_nxt.lines      = line_nxt;
      state_nxt.drive_zero = zero_nxt;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      state_r           <= '0;
      state_r.mode_sel  <= event_router_pkg::MODE_IDX_MIN;
      state_r.alarm_sel <= event_router_pkg::ALARM_IDX_MIN;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign O_RDATA      = state_r.rdata;
  assign O_LINES      = state_r.lines;
  assign O_DRIVE_ZERO = state_r.drive_zero;

endmodule

`default_nettype wire

// file: tb/router_assertions.sv
// Concurrent checks on the event output router's ports.
// Assumes it is bound into event_output_router with its parameters.
`timescale 1ns/1ps
`default_nettype none
module router_checker #(
  parameter longint unsigned SCAN_PERIOD   = 4,
  parameter longint unsigned SECOND_PERIOD = 8
) (
  input wire logic                             I_MCLK,
  input wire logic                             I_RSTN,
  input wire event_router_pkg::reg_req_type    I_REQ,
  input wire logic [15:0]                      O_RDATA,
  input wire event_router_pkg::loop_state_type I_LOOP_ONE,
  input wire logic [11:0]                      O_LINES,
  input wire logic [1:0]                       O_DRIVE_ZERO,
  input wire logic [159:0]                     O_INNER_TYPE
);
  // Shadow scan counter and PWM use, tracked from reset and writes.
  longint unsigned cnt_r;
  logic [1:0]      pwm_r;
  always_ff @(posedge I_MCLK) begin
    if (!I_RSTN) begin
      cnt_r <= 0;
      pwm_r <= 2'h0;
    end else begin
      cnt_r <= (cnt_r == SCAN_PERIOD - 1) ? 0 : cnt_r + 1;
      if (I_REQ.wr && I_REQ.addr == event_router_pkg::ADDR_PWM_USE) begin
        pwm_r <= I_REQ.wdata[1:0];
      end
    end
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);
  sequence stat_rd_s;
    I_REQ.rd && I_REQ.addr == event_router_pkg::ADDR_LINE_STAT;
  endsequence
  reset_clear_a:
    assert property ($rose(I_RSTN) |-> O_LINES == 12'h0 && O_DRIVE_ZERO == 2'h0)
    else $error("outputs not clear after reset");
  scan_hold_a:
    assert property (cnt_r != 0 |-> $stable(O_LINES) && $stable(O_DRIVE_ZERO))
    else $error("outputs changed between scan ticks");
  burnout_cause_a:
    assert property ($rose(O_DRIVE_ZERO[0]) |-> $past(I_LOOP_ONE.sensor_burnout))
    else $error("drive forced to zero without burn-out");
  rdata_idle_a:
    assert property (!I_REQ.rd |=> O_RDATA == 16'h0)
    else $error("read data outside the read answer cycle");
  step_read_a:
    assert property (I_REQ.rd && I_REQ.addr == event_router_pkg::ADDR_STEP |=> O_RDATA == 16'h0)
    else $error("step register read not zero");
  line_stat_a:
    assert property (stat_rd_s |=> O_RDATA == {2'h0, $past(O_DRIVE_ZERO), $past(O_LINES)})
    else $error("line status read differs from lines");
  pwm_mask_a:
    assert property (cnt_r == 0 |-> (O_LINES[1:0] & $past(pwm_r)) == 2'h0)
    else $error("line in PWM use was driven");
  inner_type_a:
    assert property ($past(I_RSTN) && $changed(O_INNER_TYPE) |->
      $past(I_REQ.wr) && $past(I_REQ.addr) == event_router_pkg::ADDR_ALARM_INNR)
    else $error("event type number changed without a write");
endmodule
bind event_output_router router_checker #(
  .SCAN_PERIOD(SCAN_PERIOD), .SECOND_PERIOD(SECOND_PERIOD)
) chk (
  .I_MCLK(I_MCLK), .I_RSTN(I_RSTN), .I_REQ(I_REQ), .O_RDATA(O_RDATA), .I_LOOP_ONE(I_LOOP_ONE),
  .O_LINES(O_LINES), .O_DRIVE_ZERO(O_DRIVE_ZERO), .O_INNER_TYPE(O_INNER_TYPE));
`default_nettype wire

// file: tb/relay_loads.sv
// Relay loads on the twelve discrete output terminals.
// Assumes each relay follows its line one clock later.
`timescale 1ns/1ps
`default_nettype none
module relay_loads (
  input  wire logic        i_clk,
  input  wire logic [11:0] i_lines,
  output logic      [11:0] o_energised
);
  always_ff @(posedge i_clk) begin
    o_energised <= i_lines;
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the event output router with relay loads.
// Assumes package, router, checker and relay model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int         SP   = 4;
  localparam logic [3:0] MSEL = event_router_pkg::ADDR_MODE_SEL;
  localparam logic [3:0] ASEL = event_router_pkg::ADDR_ALARM_SEL;
  localparam logic [3:0] MCFG = event_router_pkg::ADDR_MODE_CFG;
  localparam logic [3:0] ACFG = event_router_pkg::ADDR_ALARM_CFG;
  logic                             mclk, rstn;
  event_router_pkg::reg_req_type    req;
  event_router_pkg::loop_state_type lp1, lp2;
  event_router_pkg::fault_type      flt;
  logic [19:0]                      hit;
  logic [15:0]                      rdata, rd_v;
  logic [11:0]                      lines, relays;
  logic [159:0]                     itype;
  int                               fail_count, n_compared;
  event_output_router #(.SCAN_PERIOD(SP), .SECOND_PERIOD(8)) dut (
    .I_MCLK(mclk), .I_RSTN(rstn), .I_REQ(req), .O_RDATA(rdata), .I_LOOP_ONE(lp1),
    .I_LOOP_TWO(lp2), .I_FAULT(flt), .I_THRESH_HIT(hit), .O_LINES(lines),
    .O_DRIVE_ZERO(), .O_INNER_TYPE(itype));
  relay_loads loads (.i_clk(mclk), .i_lines(lines), .o_energised(relays));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req <= '0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] a);
    req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    req <= '0;
    #1 rd_v = rdata;
    @(posedge mclk);
  endtask
  task automatic sel_chk(input logic [3:0] a, input logic [15:0] d, s, exp);
    wr(a, d);
    wr(event_router_pkg::ADDR_STEP, s);
    rd(a);
    check("event_index", rd_v, exp);
  endtask
  task automatic cfg_chk(input logic [15:0] d, exp);
    wr(MCFG, d);
    rd(MCFG);
    check("mode_config", rd_v, exp);
  endtask
  // Waits past two scan ticks, then checks relays and the status word.
  task automatic expect_lines(input logic [15:0] exp);
    repeat (2 * SP + 2) @(posedge mclk);
    check("relays", {4'h0, relays}, {4'h0, exp[11:0]});
    rd(event_router_pkg::ADDR_LINE_STAT);
    check("line_status", rd_v, exp);
  endtask
  function automatic logic flg(event_router_pkg::loop_state_type s, logic [3:0] f);
    logic run;
    run = s.running | s.hold | s.tune | s.wait_st;
    case (f)
      4'h0: return s.quit | s.ready | s.end_st | s.brk | s.trouble_state;
      4'h1: return run;
      4'h2: return s.ready;
      4'h3: return s.end_st;
      4'h4: return s.trouble_state;
      4'h5: return s.hold;
      4'h6: return s.wait_st;
      4'h7: return s.tune;
      4'h8: return s.fix_mode;
      4'h9: return s.target_down & run;
      4'ha: return s.target_up & run;
      default: return 1'b0;
    endcase
  endfunction
  initial begin
    event_router_pkg::loop_state_type s1, s2;
    logic [3:0] f, sl;
    logic [1:0] src;
    logic       c, e;
    rstn = 1'b0;
    req = '0;
    lp1 = '0;
    lp2 = '0;
    flt = '0;
    hit = 20'h0;
    fail_count = 0;
    n_compared = 0;
    void'($urandom(57049));
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    for (int a = 0; a < 16; a++) begin
      rd(4'(a));
      check("reset_reg", rd_v, a == 0 ? 16'h15 : a == 1 ? 16'h3d : 16'h0);
    end
    sel_chk(MSEL, 16'h28, 16'h1, 16'h28);
    sel_chk(MSEL, 16'h28, 16'h2, 16'h27);
    sel_chk(MSEL, 16'h15, 16'h2, 16'h15);
    sel_chk(MSEL, 16'h29, 16'h0, 16'h15);
    sel_chk(MSEL, 16'h20, 16'h1, 16'h21);
    sel_chk(ASEL, 16'h50, 16'h4, 16'h50);
    sel_chk(ASEL, 16'h50, 16'h8, 16'h4f);
    sel_chk(ASEL, 16'h3c, 16'h0, 16'h4f);
    for (int i = 0; i < 44; i++) begin
      f = 4'(i % 11);
      src = 2'($urandom % 3);
      c = 1'($urandom);
      sl = 4'($urandom % 13);
      s1 = 13'($urandom);
      s2 = 13'($urandom);
      lp1 <= s1;
      lp2 <= s2;
      wr(MCFG, {4'h0, sl, 1'b0, c, src, f});
      e = src == 2'h0 ? flg(s1, f) : src == 2'h1 ? flg(s2, f) :
          c ? flg(s1, f) & flg(s2, f) : flg(s1, f) | flg(s2, f);
      expect_lines((sl != 4'h0 && e) ? 16'h1 << (sl - 4'h1) : 16'h0);
    end
    lp1 <= '{running: 1'b1, default: 1'b0};
    lp2 <= '0;
    cfg_chk(16'h0101, 16'h0101);
    wr(event_router_pkg::ADDR_PWM_USE, 16'h1);
    expect_lines(16'h0);
    cfg_chk(16'h0501, 16'h0501);
    cfg_chk(16'h0101, 16'h0501);
    cfg_chk(16'h0d01, 16'h0501);
    cfg_chk(16'h0201, 16'h0201);
    expect_lines(16'h0002);
    cfg_chk(16'h0001, 16'h0001);
    expect_lines(16'h0);
    lp1 <= '0;
    wr(ACFG, 16'h0406);
    for (int b = 0; b < 5; b++) begin
      flt <= 5'(1 << b);
      expect_lines(16'h0008);
    end
    wr(ACFG, 16'h0402);
    expect_lines(16'h0);
    lp1 <= '{hold: 1'b1, default: 1'b0};
    expect_lines(16'h0008);
    flt <= '0;
    lp1 <= '0;
    lp2 <= '{sensor_burnout: 1'b1, default: 1'b0};
    wr(ACFG, 16'h0c0d);
    expect_lines(16'h2800);
    lp2 <= '0;
    lp1 <= '{sensor_burnout: 1'b1, default: 1'b0};
    wr(ACFG, 16'h0c05);
    expect_lines(16'h1800);
    lp1 <= '0;
    wr(ACFG, 16'h0704);
    wr(event_router_pkg::ADDR_ALARM_INNR, 16'h020b);
    // Alarm 79 is still selected, so its type number is entry 18 of the bus.
    check("inner_type", {8'h0, itype[8*18 +: 8]}, 16'h000b);
    // The outside comparator is taken to be set up with its maximum above its minimum.
    hit <= 20'h40000;
    repeat (6) @(posedge mclk);
    #1 check("inner_early", {4'h0, lines}, 16'h0);
    repeat (30) @(posedge mclk);
    #1 check("inner_late", {4'h0, lines}, 16'h0040);
    tally_and_finish();
  end
endmodule
`default_nettype wire
